// ==== osc_model.sv ====
// Oscillator model standing at the far side of the clock switch.
// Assumes one clk_sys domain; pins are slow square waves derived from it.
`timescale 1ns/1ps

module osc_model
(
  input  wire logic                    clk_sys,        // System clock
  input  wire logic                    reset_n,        // Synchronous reset, active low
  input  wire logic                    pri_en,         // Primary oscillator enable
  input  wire logic                    sec_en,         // Secondary oscillator enable
  output pm_clock_pkg::osc_bits_t      osc_pins,       // Oscillator levels
  output logic                         int_osc_stable  // Internal output settled
);
  import pm_clock_pkg::*;

  logic [3:0] div_r;
  logic       stable_r;

  // Free divider; internal output settles after one lap
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      div_r    <= 4'h0;
      stable_r <= 1'b0;
    end
    else
    begin
      div_r    <= div_r + 4'h1;
      stable_r <= stable_r | (div_r == 4'hF);
    end
  end

  // Disabled oscillators stop low, as a dead crystal would
  assign osc_pins.pri    = pri_en & div_r[1];
  assign osc_pins.sec    = sec_en & div_r[3];
  assign osc_pins.intl   = div_r[2];
  assign int_osc_stable  = stable_r;
endmodule : osc_model

// ==== pm_clock_defs.svh ====
// Named constants for the power-mode clock switch.
// Assumes inclusion by the package and the switch module only.
`ifndef PM_CLOCK_DEFS_SVH
`define PM_CLOCK_DEFS_SVH

// Clock-source select field codes
`define SEL_PRI_CODE     2'h0
`define SEL_SEC_CODE     2'h1
`define SEL_INT_BIT      1

// Handover length: old-clock edges, then new-clock edges
`define SW_OLD_EDGES     2'h2
`define SW_NEW_EDGES     2'h3
`define SW_CNT_ZERO      2'h0
`define SW_CNT_ONE       2'h1

// Primary start-up timer, in primary oscillator cycles
`define OST_WIDTH        11
`define OST_CYCLES       11'h400
`define OST_ONE          11'h001
`define OST_ZERO         11'h000

// Secondary oscillator counted as running after this many edges
`define SEC_START_EDGES  4'h8
`define SEC_CNT_ZERO     4'h0
`define SEC_CNT_ONE      4'h1

// Primary oscillator configuration codes
`define PRI_CFG_XTAL_LAST 4'h2
`define PRI_CFG_HSPLL     4'h6
`define PRI_CFG_INT_A     4'h8
`define PRI_CFG_INT_B     4'h9

`endif

// ==== pm_clock_pkg.sv ====
// Types shared by the power-mode clock switch and its testbench.
// Assumes the constants header sits in the include path.
`include "pm_clock_defs.svh"

package pm_clock_pkg;

  // Clock source driving the device
  typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_INT} src_t;

  // Power state of the core
  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_SLEEP} pm_t;

  // Source switch sequencer
  typedef enum logic [1:0] {SW_STEADY, SW_WAIT, SW_OLD, SW_NEW} sw_t;

  // One bit per oscillator pin
  typedef struct packed {
    logic pri;
    logic sec;
    logic intl;
  } osc_bits_t;

  // Clock source status flags
  typedef struct packed {
    logic primary_running;
    logic internal_stable;
    logic secondary_running;
  } clk_status_t;

endpackage : pm_clock_pkg

// ==== power_mode_clock_switch.sv ====
// Power-mode selection and glitch-free system clock source switching.
// Assumes oscillator pins are free-running levels far slower than clk_sys,
// and that gating cells outside use the clock enables below.
`timescale 1ns/1ps
// Constants named here, so the file stands even when compiled on its own
`include "pm_clock_defs.svh"

module power_mode_clock_switch
  import pm_clock_pkg::*;
(
  input  wire logic                     clk_sys,             // System clock, 100 MHz
  input  wire logic                     reset_n,             // Synchronous reset, active low
  input  wire logic                     sleep_pulse,         // Sleep instruction executed
  input  wire logic                     wake_pulse,          // Wake event back to Run
  input  wire logic [1:0]               clock_source_select, // Source select field
  input  wire logic                     idle_enable,         // Idle on sleep when high
  input  wire logic                     secondary_osc_enable,// Secondary oscillator on
  input  wire logic [3:0]               primary_osc_config,  // Primary oscillator config
  input  wire logic                     fast_startup_en,     // Start on internal source
  input  wire logic                     int_fast_select,     // Internal 8 MHz output in use
  input  wire pm_clock_pkg::osc_bits_t  osc_pins,            // Raw oscillator levels
  input  wire logic                     int_osc_stable,      // Internal output settled
  output logic                          cpu_clk_en_r,        // CPU clock gate enable
  output logic                          periph_clk_en_r,     // Peripheral clock gate enable
  output logic                          pri_osc_en_r,        // Primary oscillator enable
  output pm_clock_pkg::src_t            active_r,            // Source driving the clocks
  output pm_clock_pkg::pm_t             pm_r,                // Power state
  output pm_clock_pkg::clk_status_t     status_r             // Source status flags
);
  import pm_clock_pkg::*;

  // Decode of the select field into a source
  function automatic src_t decode_sel(input logic [1:0] sel);
    if (sel[`SEL_INT_BIT])
      return SRC_INT;
    else if (sel == `SEL_SEC_CODE)
      return SRC_SEC;
    else
      return SRC_PRI;
  endfunction : decode_sel

  // Edge of the oscillator behind a given source
  function automatic logic src_bit(input src_t s, input osc_bits_t b);
    unique case (s)
      SRC_PRI: return b.pri;
      SRC_SEC: return b.sec;
      SRC_INT: return b.intl;
      default: return 1'b0;
    endcase
  endfunction : src_bit

  // Crystal configurations need the start-up timer
  function automatic logic is_crystal(input logic [3:0] cfg);
    return (cfg <= `PRI_CFG_XTAL_LAST) || (cfg == `PRI_CFG_HSPLL);
  endfunction : is_crystal

  logic [3:0]            sync1_r;
  logic [3:0]            sync2_r;
  logic [3:0]            sync3_r;
  osc_bits_t             tick;
  logic                  int_stable_s;
  logic [`OST_WIDTH-1:0] ost_cnt_r;
  logic [`OST_WIDTH-1:0] ost_cnt_nxt;
  logic [`OST_WIDTH-1:0] ost_need;
  logic [3:0]            sec_cnt_r;
  logic [3:0]            sec_cnt_nxt;
  logic                  pri_ready;
  logic                  sec_ready;
  osc_bits_t             ready;
  sw_t                   sw_r;
  src_t                  dest_r;
  logic [1:0]            sw_cnt_r;
  src_t                  sel_src;
  src_t                  tgt;
  logic                  handover;
  logic                  sec_withheld;
  logic                  clocks_on;
  logic                  old_tick;
  logic                  new_tick;
  logic                  int_primary;
  logic                  cpu_clk_en_nxt;
  logic                  periph_clk_en_nxt;
  logic                  pri_osc_en_nxt;
  clk_status_t           status_nxt;

  // Two flops before use; a third only for edge detection
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
    end
    else
    begin
      sync1_r <= {int_osc_stable, osc_pins};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Rising edges of each oscillator, seen in clk_sys
  assign tick         = osc_bits_t'(sync2_r[2:0] & ~sync3_r[2:0]);
  assign int_stable_s = sync2_r[3];

  // Start-up timer counts primary edges while the oscillator is enabled
  assign ost_need    = is_crystal(primary_osc_config) ? `OST_CYCLES : `OST_ONE;
  assign pri_ready   = (ost_cnt_r >= ost_need);
  assign ost_cnt_nxt = !pri_osc_en_r ? `OST_ZERO :
                       (tick.pri && !pri_ready) ? ost_cnt_r + `OST_ONE : ost_cnt_r;

  // Secondary counts as oscillating after a few edges
  assign sec_ready   = (sec_cnt_r == `SEC_START_EDGES);
  assign sec_cnt_nxt = !secondary_osc_enable ? `SEC_CNT_ZERO :
                       (tick.sec && !sec_ready) ? sec_cnt_r + `SEC_CNT_ONE : sec_cnt_r;
  // Slow internal source always runs, so it is always ready
  assign ready       = '{pri: pri_ready, sec: sec_ready, intl: 1'b1};

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      ost_cnt_r <= `OST_ZERO;
      sec_cnt_r <= `SEC_CNT_ZERO;
    end
    else
    begin
      ost_cnt_r <= ost_cnt_nxt;
      sec_cnt_r <= sec_cnt_nxt;
    end
  end

  // Target source; secondary with its enable clear is refused
  assign sel_src = decode_sel(clock_source_select);
  assign tgt     = (sel_src == SRC_SEC && !secondary_osc_enable) ? active_r : sel_src;

  // Handover edges: old source first, then the new one
  assign old_tick = src_bit(active_r, tick);
  assign new_tick = src_bit(dest_r, tick);
  assign handover = (sw_r == SW_OLD) || (sw_r == SW_NEW);

  // Switch sequencer; a sleep abandons a pending switch, redone after wake
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      sw_r     <= SW_STEADY;
      dest_r   <= SRC_PRI;
      sw_cnt_r <= `SW_CNT_ZERO;
      active_r <= fast_startup_en ? SRC_INT : SRC_PRI;
    end
    else if (pm_r == PM_SLEEP)
      sw_r <= SW_STEADY;
    else
    begin
      unique case (sw_r)
        SW_STEADY:
          if (tgt != active_r)
          begin
            dest_r <= tgt;
            sw_r   <= SW_WAIT;
          end
        SW_WAIT:
          if (tgt == active_r)
            sw_r <= SW_STEADY;
          else if (tgt != dest_r)
            dest_r <= tgt;
          else if (src_bit(dest_r, ready))
          begin
            sw_r     <= SW_OLD;
            sw_cnt_r <= `SW_CNT_ZERO;
          end
        SW_OLD:
          if (old_tick)
          begin
            if (sw_cnt_r == `SW_OLD_EDGES - `SW_CNT_ONE)
            begin
              sw_r     <= SW_NEW;
              sw_cnt_r <= `SW_CNT_ZERO;
            end
            else
              sw_cnt_r <= sw_cnt_r + `SW_CNT_ONE;
          end
        SW_NEW:
          if (new_tick)
          begin
            if (sw_cnt_r == `SW_NEW_EDGES - `SW_CNT_ONE)
            begin
              active_r <= dest_r;
              sw_r     <= SW_STEADY;
            end
            else
              sw_cnt_r <= sw_cnt_r + `SW_CNT_ONE;
          end
      endcase
    end
  end

  // Power state; mode sampled from idle_enable on the one-cycle sleep pulse
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      pm_r <= PM_RUN;
    else if (sleep_pulse && pm_r == PM_RUN)
      pm_r <= idle_enable ? PM_IDLE : PM_SLEEP;
    else if (wake_pulse)
      pm_r <= PM_RUN;
  end

  // Clocks off during handover and while a new secondary is not yet oscillating
  assign sec_withheld = (sw_r == SW_WAIT) && (dest_r == SRC_SEC) && !sec_ready;
  assign clocks_on    = !handover && !sec_withheld && src_bit(active_r, ready)
                        && (pm_r != PM_SLEEP);
  assign cpu_clk_en_nxt    = clocks_on && (pm_r == PM_RUN);
  assign periph_clk_en_nxt = clocks_on;

  // Primary runs while it drives or is being brought up; off in Sleep.
  // The secondary enable is never touched here, so it keeps running.
  assign pri_osc_en_nxt = (pm_r != PM_SLEEP) &&
                          (active_r == SRC_PRI ||
                           (sw_r != SW_STEADY && dest_r == SRC_PRI));

  // Status flags from the source actually in use
  assign int_primary = (primary_osc_config == `PRI_CFG_INT_A) ||
                       (primary_osc_config == `PRI_CFG_INT_B);
  assign status_nxt.primary_running   = (pm_r != PM_SLEEP) && (active_r == SRC_PRI)
                                        && pri_ready;
  assign status_nxt.internal_stable   = (pm_r != PM_SLEEP) && int_fast_select && int_stable_s
                                        && (active_r == SRC_INT ||
                                            (active_r == SRC_PRI && int_primary));
  assign status_nxt.secondary_running = (pm_r != PM_SLEEP) && (active_r == SRC_SEC);

  // All outputs registered
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      cpu_clk_en_r    <= 1'b0;
      periph_clk_en_r <= 1'b0;
      pri_osc_en_r    <= 1'b0;
      status_r        <= '0;
    end
    else
    begin
      cpu_clk_en_r    <= cpu_clk_en_nxt;
      periph_clk_en_r <= periph_clk_en_nxt;
      pri_osc_en_r    <= pri_osc_en_nxt;
      status_r        <= status_nxt;
    end
  end

  // Checks on the sequencer and the gates
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_sleep_mode_pick: assert property (
    (sleep_pulse && pm_r == PM_RUN) |=> pm_r == ($past(idle_enable) ? PM_IDLE : PM_SLEEP))
    else $error("sleep pulse picked the wrong power state");

  a_sleep_stops_all: assert property (
    (sleep_pulse && pm_r == PM_RUN && !idle_enable) |-> ##2
      (!cpu_clk_en_r && !periph_clk_en_r && !pri_osc_en_r && status_r == '0))
    else $error("sleep left a clock running");

  a_idle_cpu_off: assert property (
    (pm_r == PM_IDLE) |=> !cpu_clk_en_r)
    else $error("cpu clocked in idle");

  a_old_edge_count: assert property (
    (sw_r == SW_OLD && old_tick && sw_cnt_r == `SW_OLD_EDGES - `SW_CNT_ONE && pm_r != PM_SLEEP)
      |=> sw_r == SW_NEW && sw_cnt_r == `SW_CNT_ZERO)
    else $error("old clock edge count wrong");

  a_new_edge_done: assert property (
    (sw_r == SW_NEW && new_tick && sw_cnt_r == `SW_NEW_EDGES - `SW_CNT_ONE && pm_r != PM_SLEEP)
      |=> active_r == $past(dest_r) && sw_r == SW_STEADY)
    else $error("handover did not complete");

  a_handover_gated: assert property (
    handover |=> !periph_clk_en_r && !cpu_clk_en_r)
    else $error("clock enabled during handover");

  a_flags_exclusive: assert property (
    !(status_r.secondary_running && (status_r.primary_running || status_r.internal_stable)))
    else $error("secondary flag shares with another");

  a_int_clears_pri: assert property (
    (active_r == SRC_INT) |=> !status_r.primary_running)
    else $error("primary flag set on internal source");

  a_sec_refused: assert property (
    (sw_r == SW_STEADY && sel_src == SRC_SEC && !secondary_osc_enable
      && active_r != SRC_SEC) |=> sw_r == SW_STEADY)
    else $error("switch to disabled secondary started");

  a_pri_wait_ready: assert property (
    (sw_r == SW_WAIT && dest_r == SRC_PRI && !pri_ready) |=> sw_r != SW_OLD)
    else $error("handover before primary ready");

  a_ost_full: assert property (
    ($rose(status_r.primary_running) && is_crystal(primary_osc_config))
      |-> $past(ost_cnt_r) == `OST_CYCLES)
    else $error("primary flagged before start-up timer");

  a_primary_run_mode_flag: assert property (
    (cpu_clk_en_r && active_r == SRC_PRI) |-> status_r.primary_running)
    else $error("primary run without primary flag");

  a_sec_withheld: assert property (
    (sw_r == SW_WAIT && dest_r == SRC_SEC && !sec_ready) |=> !cpu_clk_en_r && !periph_clk_en_r)
    else $error("clock given before secondary started");

  c_sec_refused: cover property (sel_src == SRC_SEC && !secondary_osc_enable);
  c_sleep_entry: cover property (sleep_pulse && !idle_enable && pm_r == PM_RUN);
  c_idle_entry:  cover property (sleep_pulse && idle_enable && pm_r == PM_RUN);
  c_to_sec:      cover property ($rose(status_r.secondary_running));
  c_back_to_pri: cover property (status_r.secondary_running ##[1:1000] status_r.primary_running);

endmodule : power_mode_clock_switch

// ==== tb.sv ====
// Self-checking bench for the power-mode clock switch.
// Assumes the package, the switch and the oscillator model are compiled first.
`timescale 1ns/1ps

module tb;
  import pm_clock_pkg::*;

  typedef struct packed {logic idle; pm_t pm; logic cpu; logic per;} row_t;

  logic        clk_sys, reset_n, sleep_pulse, wake_pulse, idle_enable;
  logic        secondary_osc_enable, fast_startup_en, int_fast_select, int_osc_stable;
  logic [1:0]  clock_source_select;
  logic [3:0]  primary_osc_config;
  osc_bits_t   osc_pins;
  logic        cpu_clk_en_r, periph_clk_en_r, pri_osc_en_r;
  src_t        active_r;
  pm_t         pm_r;
  clk_status_t status_r;
  int          fails, checks_done, cycles, n;
  row_t        rows [4];

  power_mode_clock_switch dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .sleep_pulse(sleep_pulse), .wake_pulse(wake_pulse),
    .clock_source_select(clock_source_select), .idle_enable(idle_enable),
    .secondary_osc_enable(secondary_osc_enable), .primary_osc_config(primary_osc_config),
    .fast_startup_en(fast_startup_en), .int_fast_select(int_fast_select),
    .osc_pins(osc_pins), .int_osc_stable(int_osc_stable), .cpu_clk_en_r(cpu_clk_en_r),
    .periph_clk_en_r(periph_clk_en_r), .pri_osc_en_r(pri_osc_en_r),
    .active_r(active_r), .pm_r(pm_r), .status_r(status_r));

  osc_model u_osc (.clk_sys(clk_sys), .reset_n(reset_n), .pri_en(pri_osc_en_r),
    .sec_en(secondary_osc_enable), .osc_pins(osc_pins), .int_osc_stable(int_osc_stable));

  // Clock, 10 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Hang guard; four crystal primary start-ups after the first reset dominate the run
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic chk_bit(string nm, logic exp, logic got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_bit

  task automatic chk_code(string nm, logic [1:0] exp, logic [1:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_code

  // Inputs always move 1 ns after the rising edge
  task automatic step(int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : step

  task automatic pulse(bit wk);
    if (wk)
      wake_pulse = 1'b1;
    else
      sleep_pulse = 1'b1;
    step(1);
    wake_pulse  = 1'b0;
    sleep_pulse = 1'b0;
  endtask : pulse

  task automatic wait_cpu(int max, output int cnt);
    cnt = 0;
    while (cpu_clk_en_r !== 1'b1 && cnt < max)
    begin
      step(1);
      cnt++;
    end
  endtask : wait_cpu

  task automatic wait_src(logic [1:0] s, int max, output int cnt);
    cnt = 0;
    while (active_r !== s && cnt < max)
    begin
      step(1);
      cnt++;
    end
  endtask : wait_src

  task automatic do_reset(logic fast, logic [3:0] cfg);
    reset_n              = 1'b0;
    fast_startup_en      = fast;
    primary_osc_config   = cfg;
    clock_source_select  = 2'h0;
    idle_enable          = 1'b0;
    secondary_osc_enable = 1'b0;
    int_fast_select      = 1'b0;
    step(20);
    reset_n = 1'b1;
  endtask : do_reset

  // Main sequence: sleep/idle rows, then source switches and resets
  initial
  begin
    fails = 0;
    checks_done = 0;
    cycles = 0;
    sleep_pulse = 1'b0;
    wake_pulse = 1'b0;
    rows = '{'{1'b0, PM_SLEEP, 1'b0, 1'b0}, '{1'b1, PM_IDLE, 1'b0, 1'b1},
             '{1'b1, PM_IDLE, 1'b0, 1'b1}, '{1'b0, PM_SLEEP, 1'b0, 1'b0}};
    do_reset(1'b0, 4'h0);
    chk_code("pm_r", PM_RUN, pm_r);
    chk_code("active_r", SRC_PRI, active_r);
    step(100);
    chk_bit("cpu_clk_en_r", 1'b0, cpu_clk_en_r);
    wait_cpu(8000, n);
    chk_bit("startup_long", 1'b1, n > 1900);
    chk_bit("primary_running", 1'b1, status_r.primary_running);
    chk_bit("secondary_running", 1'b0, status_r.secondary_running);
    foreach (rows[i])
    begin
      idle_enable = rows[i].idle;
      step(1);
      pulse(1'b0);
      chk_code("pm_r", rows[i].pm, pm_r);
      step(1);
      chk_bit("cpu_clk_en_r", rows[i].cpu, cpu_clk_en_r);
      chk_bit("periph_clk_en_r", rows[i].per, periph_clk_en_r);
      chk_bit("pri_osc_en_r", rows[i].per, pri_osc_en_r);
      chk_bit("primary_running", rows[i].per, status_r.primary_running);
      pulse(1'b1);
      wait_cpu(8000, n);
      chk_code("pm_r", PM_RUN, pm_r);
    end
    clock_source_select = 2'h1;
    step(200);
    chk_code("active_r", SRC_PRI, active_r);
    secondary_osc_enable = 1'b1;
    step(20);
    chk_bit("cpu_clk_en_r", 1'b0, cpu_clk_en_r);
    wait_src(SRC_SEC, 2000, n);
    step(2);
    chk_code("active_r", SRC_SEC, active_r);
    chk_bit("secondary_running", 1'b1, status_r.secondary_running);
    chk_bit("primary_running", 1'b0, status_r.primary_running);
    chk_bit("pri_osc_en_r", 1'b0, pri_osc_en_r);
    clock_source_select = 2'h0;
    step(500);
    chk_code("active_r", SRC_SEC, active_r);
    chk_bit("cpu_clk_en_r", 1'b1, cpu_clk_en_r);
    wait_src(SRC_PRI, 8000, n);
    step(2);
    chk_bit("primary_running", 1'b1, status_r.primary_running);
    chk_bit("secondary_running", 1'b0, status_r.secondary_running);
    int_fast_select = 1'b1;
    clock_source_select = 2'h2;
    wait_src(SRC_INT, 200, n);
    chk_bit("switch_len", 1'b1, n >= 12 && n <= 60);
    step(2);
    chk_bit("internal_stable", 1'b1, status_r.internal_stable);
    chk_bit("primary_running", 1'b0, status_r.primary_running);
    // Mid-run reset with the internal block as primary source
    do_reset(1'b0, 4'h8);
    int_fast_select = 1'b1;
    wait_cpu(500, n);
    step(16);
    chk_bit("primary_running", 1'b1, status_r.primary_running);
    chk_bit("internal_stable", 1'b1, status_r.internal_stable);
    clock_source_select = 2'h3;
    wait_src(SRC_INT, 200, n);
    step(2);
    chk_bit("primary_running", 1'b0, status_r.primary_running);
    chk_bit("internal_stable", 1'b1, status_r.internal_stable);
    do_reset(1'b1, 4'h0);
    chk_code("active_r", SRC_INT, active_r);
    tally_and_finish();
  end
endmodule : tb
